// ### inc/lpm_pkg.sv
// Constants and types for the low-power mode controller
// Assumes a 50 MHz pclk and an APB master outside
package lpm_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] lpm_mode_offset   = 12'h000;
  localparam logic [11:0] lpm_cfg_offset    = 12'h004;
  localparam logic [11:0] lpm_status_offset = 12'h008;
  localparam logic [11:0] lpm_wake_offset   = 12'h00c;

  // ==========================================================
  // Field positions
  localparam int lpm_cfg_per_pll_pos   = 0;
  localparam int lpm_cfg_audio_osc_pos = 1;
  localparam int lpm_wake_pos          = 0;

  // ==========================================================
  // Reset values
  localparam logic [1:0]  lpm_mode_reset = 2'h0;
  localparam logic [31:0] lpm_cfg_reset  = 32'h0000_0000;
  localparam logic [15:0] lpm_gate_reset = 16'h0000;

  // ==========================================================
  // Timing: settle time of clocks before core enters wfi
  localparam int lpm_settle_ns     = 100;
  localparam int lpm_clk_period_ns = 20;
  localparam int lpm_settle_cycles = (lpm_settle_ns + lpm_clk_period_ns - 1) / lpm_clk_period_ns;

  typedef enum logic [1:0] {
    lpm_wait_mode,
    lpm_doze_mode,
    lpm_stop_mode,
    lpm_static_mode
  } lpm_mode_type;

  typedef struct packed {
    logic        crossbar_run;
    logic        core_pll_on;
    logic        per_pll_on;
    logic        osc24_on;
    logic        audio_osc_on;
    logic        random_generator_osc_on;
    logic        cache_ctrl_on;
    logic        write_buffer_logic_en;
    logic        cache_array_pwr;
    logic        core_wfi;
    logic [15:0] module_clk_en;
  } lpm_ctrl_type;

endpackage : lpm_pkg

// ### logic/lpm_ctrl.sv
// Low-power mode controller: drives clock, PLL and oscillator enables
// Assumes an APB master, synchronous wake input, 50 MHz pclk
`timescale 1ns/1ns

module lpm_ctrl
  import lpm_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic              pslverr,
  output logic [31:0]       prdata,
  input  wire logic         wake_event,
  output lpm_ctrl_type      ctrl
);

  // ==========================================================
  // Register state
  lpm_mode_type mode;
  logic [31:0]  cfg;
  logic [15:0]  clock_gate_register;
  logic         low_power;
  logic [7:0]   settle_cnt;
  lpm_ctrl_type next_ctrl;

  wire logic wr_acc = psel && penable && pwrite;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == lpm_mode_offset) || (a == lpm_cfg_offset)
            || (a == lpm_status_offset) || (a == lpm_wake_offset);
  endfunction : addr_hit

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= lpm_wait_mode;
      cfg  <= lpm_cfg_reset;
    end else if (wr_acc && paddr == lpm_mode_offset) begin
      mode <= lpm_mode_type'(pwdata[1:0]);
    end else if (wr_acc && paddr == lpm_cfg_offset) begin
      cfg <= pwdata;
    end
  end

  // Gate register shares the cfg word upper half
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_gate_register <= lpm_gate_reset;
    end else if (wr_acc && paddr == lpm_cfg_offset) begin
      clock_gate_register <= pwdata[31:16];
    end
  end

  // Entry by writing wake register bit 0 low; wake leaves low power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power  <= 1'b0;
      settle_cnt <= 8'h00;
    end else if (wake_event) begin
      low_power  <= 1'b0;
      settle_cnt <= 8'h00;
    end else if (wr_acc && paddr == lpm_wake_offset && !pwdata[lpm_wake_pos] && !low_power) begin
      // A second entry write must not reload the count and drop wfi
      low_power  <= 1'b1;
      settle_cnt <= 8'(lpm_settle_cycles);
    end else if (settle_cnt != 8'h00) begin
      settle_cnt <= settle_cnt - 8'h01;
    end
  end

  // ==========================================================
  // Run arrangement: everything on but write buffer logic, core free to execute
  function automatic lpm_ctrl_type run_arrangement();
    lpm_ctrl_type r;
    r = '0;
    r.crossbar_run            = 1'b1;
    r.core_pll_on             = 1'b1;
    r.per_pll_on              = 1'b1;
    r.osc24_on                = 1'b1;
    r.audio_osc_on            = 1'b1;
    r.random_generator_osc_on = 1'b1;
    r.cache_ctrl_on           = 1'b1;
    r.write_buffer_logic_en   = 1'b0;
    r.cache_array_pwr         = 1'b1;
    r.core_wfi                = 1'b0;
    r.module_clk_en           = 16'hffff;
    run_arrangement = r;
  endfunction : run_arrangement

  // ==========================================================
  // Low-power arrangement, every mode-dependent field named per mode
  // Spelling each mode out costs lines but hides no field in a default
  function automatic lpm_ctrl_type arrangement(
    input lpm_mode_type md,
    input logic         per_pll_cfg,
    input logic         audio_cfg,
    input logic [15:0]  gate
  );
    lpm_ctrl_type a;
    a = '0;
    // Cache array stays powered so contents survive
    a.cache_array_pwr         = 1'b1;
    a.random_generator_osc_on = 1'b0;
    a.osc24_on                = 1'b1;
    case (md)
      lpm_wait_mode: begin
        a.crossbar_run          = 1'b1;
        a.core_pll_on           = 1'b1;
        a.per_pll_on            = per_pll_cfg;
        a.audio_osc_on          = audio_cfg;
        a.cache_ctrl_on         = 1'b1;
        a.write_buffer_logic_en = 1'b0;
        a.module_clk_en         = gate;
      end

      lpm_doze_mode: begin
        a.crossbar_run          = 1'b0;
        a.core_pll_on           = 1'b1;
        a.per_pll_on            = per_pll_cfg;
        a.audio_osc_on          = audio_cfg;
        a.cache_ctrl_on         = 1'b0;
        a.write_buffer_logic_en = 1'b1;
        a.module_clk_en         = gate;
      end

      lpm_stop_mode: begin
        // Only the 24 MHz oscillator keeps running
        a.crossbar_run          = 1'b0;
        a.core_pll_on           = 1'b0;
        a.per_pll_on            = 1'b0;
        a.audio_osc_on          = 1'b0;
        a.cache_ctrl_on         = 1'b0;
        a.write_buffer_logic_en = 1'b1;
        a.module_clk_en         = 16'h0000;
      end

      lpm_static_mode: begin
        a.crossbar_run          = 1'b0;
        a.core_pll_on           = 1'b0;
        a.per_pll_on            = 1'b0;
        a.audio_osc_on          = 1'b0;
        a.cache_ctrl_on         = 1'b0;
        a.write_buffer_logic_en = 1'b1;
        a.module_clk_en         = 16'h0000;
      end

      default: begin
        a = run_arrangement();
      end
    endcase
    arrangement = a;
  endfunction : arrangement

  // ==========================================================
  // Mode decode
  // Core holds off wfi until the settle count has run out
  always_comb begin
    next_ctrl = run_arrangement();
    if (low_power) begin
      next_ctrl = arrangement(mode, cfg[lpm_cfg_per_pll_pos], cfg[lpm_cfg_audio_osc_pos],
                              clock_gate_register);
      next_ctrl.core_wfi = (settle_cnt == 8'h00);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // ==========================================================
  // Read data registered during setup so it is stable at access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        lpm_mode_offset:   prdata <= {30'h0, mode};
        lpm_cfg_offset:    prdata <= {clock_gate_register, cfg[15:0]};
        lpm_status_offset: prdata <= {ctrl[25:0], 5'h00, low_power};
        lpm_wake_offset:   prdata <= {31'h0, !low_power};
        default:           prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : lpm_ctrl

// ### sim/lpm_pwr_mgr.sv
// Power manager model: supply groups in order, then power-on reset
// Assumes rails report good as soon as switched; waits are in pclk cycles
`timescale 1ns/1ns
module lpm_pwr_mgr #(
  parameter int core_wait_cycles = 1600,
  parameter int rest_wait_cycles = 5000
) (
  input  wire logic pclk,
  input  wire logic power_down,
  output logic      presetn
);
  logic core_io_on          = 1'b0;
  logic rest_on             = 1'b0;
  logic fuse_program_supply = 1'b0;
  logic core_io_good;
  logic rest_good;
  int   count = 0;
  initial presetn = 1'b0;
  assign core_io_good = core_io_on;
  assign rest_good    = rest_on;
  always @(posedge pclk) begin
    if (power_down) begin
      // Reverse order preferred; all at once is allowed
      presetn    <= 1'b0;
      rest_on    <= 1'b0;
      core_io_on <= 1'b0;
      count      <= 0;
    end else if (!core_io_on) begin
      core_io_on <= 1'b1;
    end else if (core_io_good && !rest_on) begin
      if (count < core_wait_cycles) count <= count + 1;
      else begin
        rest_on <= 1'b1;
        count   <= 0;
      end
    end else if (rest_good && !presetn) begin
      if (count < rest_wait_cycles) count <= count + 1;
      else presetn <= 1'b1;
    end
  end
endmodule : lpm_pwr_mgr

// ### sim/lpm_ctrl_monitor.sv
// Checker for the low-power mode outputs
// Assumes one pclk domain and active-low presetn
`timescale 1ns/1ns
module lpm_ctrl_monitor
  import lpm_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         wake_event,
  input wire lpm_ctrl_type ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Mode arrangements, told apart by crossbar and core PLL
  wfi_cache_a: assert property (ctrl.core_wfi |-> ctrl.cache_array_pwr && !ctrl.random_generator_osc_on)
    else $error("cache power or random osc wrong");
  wfi_hold_a: assert property (ctrl.core_wfi && !wake_event && !$past(wake_event) |=> ctrl.core_wfi)
    else $error("core left wfi without wake");
  wake_exit_a: assert property (wake_event && ctrl.core_wfi |-> ##[1:3] !ctrl.core_wfi)
    else $error("wake did not end wfi");
  wait_clk_a: assert property (ctrl.core_wfi && ctrl.crossbar_run |-> ctrl.core_pll_on && ctrl.osc24_on)
    else $error("wait clocks wrong");
  doze_a: assert property (ctrl.core_wfi && !ctrl.crossbar_run && ctrl.core_pll_on
    |-> !ctrl.cache_ctrl_on && ctrl.write_buffer_logic_en)
    else $error("doze arrangement wrong");
  stop_a: assert property (ctrl.core_wfi && !ctrl.core_pll_on |-> !ctrl.per_pll_on && !ctrl.audio_osc_on
    && ctrl.osc24_on && ctrl.module_clk_en == 16'h0000)
    else $error("stop arrangement wrong");
endmodule : lpm_ctrl_monitor
bind lpm_ctrl lpm_ctrl_monitor lpm_ctrl_monitor_inst (.pclk, .presetn, .wake_event, .ctrl);

// ### sim/testbench.sv
// Bench: APB tasks, all four low-power modes
// Assumes zero wait states are not relied on
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("ERROR %0t mismatch", $time); end end
module testbench;
  import lpm_pkg::*;
  logic         pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0, wake_event = 0, pready, pslverr, err;
  logic         power_down = 0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0, prdata, rd;
  lpm_ctrl_type ctrl, e, m;
  int           fails = 0, total_checks = 0, cycles = 0;
  always #10 pclk = ~pclk;
  // Supply waits scaled down so reset lifts after about 20 cycles
  lpm_pwr_mgr #(.core_wait_cycles(8), .rest_wait_cycles(10)) lpm_pwr_mgr_inst (.pclk, .power_down, .presetn);
  lpm_ctrl lpm_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
    .prdata, .wake_event, .ctrl);
  task automatic complete_run;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Idle cycle after each transfer, so no signal is set twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin fails++; complete_run(); end
  end
  // ==========================================================
  // Main sequence
  initial begin
    @(posedge presetn); @(posedge pclk);
    apb(0, lpm_cfg_offset, 32'h0); `CHK(rd, lpm_cfg_reset)
    apb(1, 12'h010, 32'h1); `CHK(err, 1'b1)
    for (int md = 0; md < 4; md++) begin
      apb(1, lpm_cfg_offset, 32'h5a5a_0003);
      apb(1, lpm_mode_offset, 32'(md));
      apb(1, lpm_wake_offset, 32'h0);
      repeat (10) @(posedge pclk);
      e = '0; m = '1;
      e.core_wfi = 1; e.cache_array_pwr = 1; e.osc24_on = 1; e.write_buffer_logic_en = (md != 0);
      if (md < 2) begin
        e.core_pll_on = 1; e.per_pll_on = 1; e.audio_osc_on = 1; e.module_clk_en = 16'h5a5a; e.crossbar_run = (md == 0);
      end
      // Wait leaves cache control and write buffer open
      if (md == 0) begin m.cache_ctrl_on = 0; m.write_buffer_logic_en = 0; end
      `CHK(ctrl & m, e)
      wake_event <= 1'b1;
      @(posedge pclk) wake_event <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(ctrl.core_wfi, 1'b0)
      apb(0, lpm_wake_offset, 32'h0); `CHK(rd[0], 1'b1)
    end
    // Mid-run power cycle: all rails off at once, then full start-up again
    power_down <= 1'b1;
    @(posedge pclk) power_down <= 1'b0;
    @(posedge pclk);
    `CHK(presetn, 1'b0)
    e = '0;
    `CHK(ctrl, e)
    @(posedge presetn);
    repeat (2) @(posedge pclk);
    e = '1; e.write_buffer_logic_en = 0; e.core_wfi = 0;
    `CHK(ctrl, e)
    apb(0, lpm_mode_offset, 32'h0); `CHK(rd[1:0], lpm_mode_reset)
    complete_run();
  end
endmodule : testbench
